// ### rtl/fsp_pkg.sv
package fsp_pkg;

  // ------------------------------------------------------------
  // Serial frame layout
  // ------------------------------------------------------------
  localparam int          FRAME_BITS = 16;
  localparam int          CMD_BIT    = 15;
  localparam int          ADDR_LSB   = 11;
  localparam int          ADDR_W     = 4;
  localparam logic [3:0]  CTRL_ADDR  = 4'h4;
  localparam logic [3:0]  STAT_ADDR  = 4'hE;
  localparam logic [15:0] NOP_ONES   = 16'hFFFF;
  localparam logic [15:0] ERR_REPLY  = 16'h8000;

  // ------------------------------------------------------------
  // Control register layout
  // ------------------------------------------------------------
  localparam int          CTRL_W    = 10;
  localparam int          MODE_LSB  = 2;
  localparam int          MODE_W    = 3;
  localparam int          EN_LSB    = 0;
  localparam int          EN_W      = 2;
  localparam logic [9:0]  CTRL_RST  = 10'h000;

  // ------------------------------------------------------------
  // Mode field codes
  // ------------------------------------------------------------
  localparam logic [2:0]  MODE_OFF  = 3'h0;
  localparam logic [2:0]  MODE_OTP  = 3'h1;

  typedef enum logic [2:0] {
    ST_INIT = 3'b001,
    ST_RUN  = 3'b010,
    ST_SAFE = 3'b100
  } fsp_state_t;

  // Modes in which the reset pin enters and leaves fail-safe.
  function automatic logic pin_safe(input logic [2:0] m);
    pin_safe = (m >= 3'h2) && (m <= 3'h5);
  endfunction : pin_safe

  // Modes that keep serial writes open during fail-safe.
  function automatic logic spi_open(input logic [2:0] m);
    spi_open = m[0];
  endfunction : spi_open

  // Stand-alone modes.
  function automatic logic stand_alone(input logic [2:0] m);
    stand_alone = m[2] & m[1];
  endfunction : stand_alone

  // Modes that load the control register from OTP at power-on.
  function automatic logic por_load(input logic [2:0] m);
    por_load = (m == MODE_OTP) || m[2];
  endfunction : por_load

endpackage : fsp_pkg

// ### rtl/fsp_spi_shift.sv
module fsp_spi_shift #(
  parameter int FRAME_W = fsp_pkg::FRAME_BITS
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // Serial pins
  input  wire logic               chip_select_n,
  input  wire logic               sclk,
  input  wire logic               sdi,
  output logic                    sdo_o,
  output logic                    sdo_oe_n,
  // Frame side
  input  wire logic [FRAME_W-1:0] tx_word,
  output logic      [FRAME_W-1:0] rx_word,
  output logic                    frame_ok,
  output logic                    frame_bad,
  output logic                    daisy_mode
);

  localparam int CW = $clog2(FRAME_W);

  logic [1:0]         cs_s;
  logic [1:0]         sck_s;
  logic [1:0]         sdi_s;
  logic               cs_prev_q;
  logic               sck_prev_q;
  logic [FRAME_W-1:0] shift_q;
  logic [CW-1:0]      cnt_q;
  logic [1:0]         wraps_q;
  logic               zeros_q;
  logic               ok_q;
  logic               bad_q;
  logic               daisy_q;
  logic               sdo_q;
  logic [FRAME_W-1:0] rx_q;

  // ------------------------------------------------------------
  // Pin edge detection
  // ------------------------------------------------------------
  wire sel      = ~cs_s[1];
  wire cs_start = cs_prev_q & ~cs_s[1];
  wire cs_end   = ~cs_prev_q & cs_s[1];
  wire sck_rise = sel & sck_s[1] & ~sck_prev_q;
  wire sck_fall = sel & ~sck_s[1] & sck_prev_q;
  wire whole    = (cnt_q == '0) && (wraps_q != 2'h0);
  wire single   = wraps_q == 2'h1;
  wire to_daisy = whole & zeros_q;
  wire good     = whole & ~zeros_q & (daisy_q | single);

  always_ff @(posedge clk_sys) begin
    cs_s       <= {cs_s[0], chip_select_n};
    sck_s      <= {sck_s[0], sclk};
    sdi_s      <= {sdi_s[0], sdi};
    cs_prev_q  <= cs_s[1];
    sck_prev_q <= sck_s[1];
  end

  // ------------------------------------------------------------
  // Shift register, full duplex
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst)
    begin
      shift_q <= '0;
      cnt_q   <= '0;
      wraps_q <= 2'h0;
      zeros_q <= 1'b1;
    end
    else if (cs_start)
    begin
      if (!daisy_q)
      begin
        shift_q <= tx_word;
      end
      cnt_q   <= '0;
      wraps_q <= 2'h0;
      zeros_q <= 1'b1;
    end
    else if (sck_rise)
    begin
      shift_q <= {shift_q[FRAME_W-2:0], sdi_s[1]};
      cnt_q   <= cnt_q + 1'b1;
      zeros_q <= zeros_q & ~sdi_s[1];
      if (cnt_q == CW'(FRAME_W - 1) && wraps_q != 2'h3)
      begin
        wraps_q <= wraps_q + 2'h1;
      end
    end
  end

  // Output bits are launched on the falling serial clock edge.
  always_ff @(posedge clk_sys) begin
    if (rst)
    begin
      sdo_q <= 1'b0;
    end
    else if (cs_start)
    begin
      sdo_q <= daisy_q ? shift_q[FRAME_W-1] : tx_word[FRAME_W-1];
    end
    else if (sck_fall)
    begin
      sdo_q <= shift_q[FRAME_W-1];
    end
  end

  // ------------------------------------------------------------
  // Frame end checks and bus arrangement
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst)
    begin
      ok_q    <= 1'b0;
      bad_q   <= 1'b0;
      daisy_q <= 1'b0;
      rx_q    <= '0;
    end
    else
    begin
      ok_q  <= cs_end & good;
      bad_q <= cs_end & ~whole;
      if (cs_end && good)
      begin
        rx_q <= shift_q;
      end
      if (cs_end && to_daisy)
      begin
        daisy_q <= 1'b1;
      end
      else if (cs_end && good && shift_q == fsp_pkg::NOP_ONES)
      begin
        daisy_q <= 1'b0;
      end
    end
  end

  assign rx_word    = rx_q;
  assign frame_ok   = ok_q;
  assign frame_bad  = bad_q;
  assign daisy_mode = daisy_q;
  assign sdo_o      = sdo_q;
  assign sdo_oe_n   = cs_s[1];

endmodule : fsp_spi_shift

// ### rtl/fsp_failsafe_ctrl.sv
// Behaviour
// - Mode 000: control register cleared after reset.
// - Mode 000: fail-safe only after serial mode change.
// - Mode 001: OTP load, no fail-safe, needs lock.
// - Modes 000/001: pin resets, LED pins work.
// - Modes 010/011: clear except mode; pin fall enters.
// - Modes 100/101: OTP load; pin fall enters.
// - Fail-safe entry reloads register from OTP.
// - Modes 010/100/110: writes blocked, errors still flagged.
// - Modes 011/101/111: writes open; mode 000/001 exits.
// - Modes 010-101: pin enters/leaves fail-safe, no reset.
// - Modes 110/111: stand-alone on pin rise, pin resets.
// - Fail-safe ignores LED pins; enable bits only.
// - Device is slave only, never starts transfers.
// - Sixteen-bit frames, full duplex shifting.
// - Active low select; output released when idle.
// - Launch on falling edge, sample on rising.
// - Star and daisy-chain arrangements supported.
// - Entry sets fail-safe flag; status read clears only while writes are open.
// - Pin-entered fail-safe blocks reset; pin rise exits.
// - Mode latched on entry; cleared at reset/exit.
// - Star at power-up; all-zero whole frames select daisy.
module fsp_failsafe_ctrl (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  // Device pins
  input  wire logic                        external_reset_pin,
  input  wire logic [fsp_pkg::EN_W-1:0]    led_channel_control_pin,
  // Serial link
  input  wire logic                        chip_select_n,
  input  wire logic                        sclk,
  input  wire logic                        sdi,
  output logic                             sdo_o,
  output logic                             sdo_oe_n,
  // One-time-programmable memory
  input  wire logic                        otp_lock,
  input  wire logic [fsp_pkg::CTRL_W-1:0]  otp_image,
  // Control and status
  output logic      [fsp_pkg::CTRL_W-1:0]  ctrl_reg,
  output logic      [fsp_pkg::MODE_W-1:0]  latched_mode,
  output logic                             init_busy,
  output logic                             failsafe_operation,
  output logic                             standalone_operation,
  output logic                             failsafe_flag,
  output logic                             serial_error_flag,
  output logic                             daisy_mode,
  output logic      [fsp_pkg::EN_W-1:0]    channel_drive
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  localparam int FW = fsp_pkg::FRAME_BITS;
  localparam int CW = fsp_pkg::CTRL_W;
  localparam int MW = fsp_pkg::MODE_W;
  localparam int EW = fsp_pkg::EN_W;

  fsp_pkg::fsp_state_t state_q;
  fsp_pkg::fsp_state_t state_d;

  logic [1:0]    rpin_s;
  logic          rpin_prev_q;
  logic [EW-1:0] led_s1_q;
  logic [EW-1:0] led_s2_q;
  logic [CW-1:0] ctrl_q;
  logic [CW-1:0] ctrl_d;
  logic [MW-1:0] latch_q;
  logic [MW-1:0] latch_d;
  logic          safe_set;
  logic          safe_flag_q;
  logic          err_flag_q;
  logic [EW-1:0] drive_q;
  logic [EW-1:0] drive_d;
  logic [FW-1:0] tx_q;
  logic [FW-1:0] tx_d;
  logic [FW-1:0] rx_word;
  logic          frame_ok;
  logic          frame_bad;

  // Keeps only the mode field of an image, all else zero.
  function automatic logic [CW-1:0] mode_only(input logic [MW-1:0] m);
    logic [CW-1:0] v;
    v                      = fsp_pkg::CTRL_RST;
    v[fsp_pkg::MODE_LSB+:MW] = m;
    mode_only              = v;
  endfunction : mode_only

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    rpin_s      <= {rpin_s[0], external_reset_pin};
    rpin_prev_q <= rpin_s[1];
    led_s1_q    <= led_channel_control_pin;
    led_s2_q    <= led_s1_q;
  end

  wire rpin_high = rpin_s[1];
  wire rpin_fall = rpin_prev_q & ~rpin_s[1];
  wire rpin_rise = ~rpin_prev_q & rpin_s[1];

  // ------------------------------------------------------------
  // Serial front end
  // ------------------------------------------------------------
  fsp_spi_shift #(
    .FRAME_W (FW)
  ) u_shift (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .chip_select_n (chip_select_n),
    .sclk          (sclk),
    .sdi           (sdi),
    .sdo_o         (sdo_o),
    .sdo_oe_n      (sdo_oe_n),
    .tx_word       (tx_q),
    .rx_word       (rx_word),
    .frame_ok      (frame_ok),
    .frame_bad     (frame_bad),
    .daisy_mode    (daisy_mode)
  );

  // ------------------------------------------------------------
  // Frame decode
  // ------------------------------------------------------------
  wire                   is_write = rx_word[fsp_pkg::CMD_BIT];
  wire [3:0]             addr     = rx_word[fsp_pkg::ADDR_LSB+:fsp_pkg::ADDR_W];
  wire [CW-1:0]          wdata    = rx_word[CW-1:0];
  wire [MW-1:0]          new_mode = wdata[fsp_pkg::MODE_LSB+:MW];
  wire [MW-1:0]          reg_mode = ctrl_q[fsp_pkg::MODE_LSB+:MW];
  wire [MW-1:0]          otp_mode = otp_image[fsp_pkg::MODE_LSB+:MW];
  wire [EW-1:0]          ctrl_en  = ctrl_q[fsp_pkg::EN_LSB+:EW];

  wire in_init  = state_q == fsp_pkg::ST_INIT;
  wire in_run   = state_q == fsp_pkg::ST_RUN;
  wire in_safe  = state_q == fsp_pkg::ST_SAFE;
  wire solo_now = fsp_pkg::stand_alone(latch_q);

  // Without the lock bit the image is not trusted and mode 000 rules.
  wire [MW-1:0] por_mode = otp_lock ? otp_mode : fsp_pkg::MODE_OFF;

  // Writes and read-to-clear are closed in fail-safe unless the latched mode allows.
  wire spi_live = in_run | (in_safe & fsp_pkg::spi_open(latch_q));
  wire wr_ctrl  = frame_ok & is_write & (addr == fsp_pkg::CTRL_ADDR) & spi_live;
  wire rd_ctrl  = frame_ok & ~is_write & (addr == fsp_pkg::CTRL_ADDR);
  wire rd_stat  = frame_ok & ~is_write & (addr == fsp_pkg::STAT_ADDR);
  wire rd_clear = rd_stat & spi_live;

  wire exit_code = (new_mode == fsp_pkg::MODE_OFF) | (new_mode == fsp_pkg::MODE_OTP);
  wire spi_exit  = wr_ctrl & in_safe & exit_code;

  // Pin entry needs a pin-driven mode and a locked OTP image.
  wire pin_enter = fsp_pkg::pin_safe(reg_mode) & otp_lock;

  // ------------------------------------------------------------
  // Mode state machine
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    ctrl_d  = wr_ctrl ? wdata : ctrl_q;
    latch_d  = latch_q;
    safe_set = 1'b0;
    case (state_q)
      fsp_pkg::ST_INIT:
      begin
        ctrl_d = fsp_pkg::CTRL_RST;
        if (rpin_high)
        begin
          if (fsp_pkg::stand_alone(por_mode))
          begin
            state_d  = fsp_pkg::ST_SAFE;
            ctrl_d   = otp_image;
            latch_d  = por_mode;
            safe_set = 1'b1;
          end
          else if (fsp_pkg::por_load(por_mode))
          begin
            state_d = fsp_pkg::ST_RUN;
            ctrl_d  = otp_image;
          end
          else
          begin
            state_d = fsp_pkg::ST_RUN;
            ctrl_d  = mode_only(por_mode);
          end
        end
      end
      fsp_pkg::ST_RUN:
      begin
        if (rpin_fall && pin_enter)
        begin
          state_d  = fsp_pkg::ST_SAFE;
          ctrl_d   = otp_image;
          latch_d  = reg_mode;
          safe_set = 1'b1;
        end
        else if (rpin_fall)
        begin
          state_d = fsp_pkg::ST_INIT;
          ctrl_d  = fsp_pkg::CTRL_RST;
        end
      end
      fsp_pkg::ST_SAFE:
      begin
        if (solo_now && rpin_fall)
        begin
          state_d = fsp_pkg::ST_INIT;
          ctrl_d  = fsp_pkg::CTRL_RST;
          latch_d = '0;
        end
        else if ((!solo_now && rpin_rise) || spi_exit)
        begin
          state_d = fsp_pkg::ST_RUN;
          latch_d = '0;
        end
      end
      default:
      begin
        state_d = fsp_pkg::ST_INIT;
        ctrl_d  = fsp_pkg::CTRL_RST;
        latch_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst)
    begin
      state_q <= fsp_pkg::ST_INIT;
      ctrl_q  <= fsp_pkg::CTRL_RST;
      latch_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      ctrl_q  <= ctrl_d;
      latch_q <= latch_d;
    end
  end

  // ------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------
  wire to_init = (state_d == fsp_pkg::ST_INIT) & ~in_init;

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (rst)
    begin
      safe_flag_q <= 1'b0;
      err_flag_q <= 1'b0;
    end
    else
    begin
      safe_flag_q <= safe_set | (safe_flag_q & ~rd_clear & ~to_init);
      err_flag_q <= frame_bad | (err_flag_q & ~rd_clear & ~to_init);
    end
  end

  // ------------------------------------------------------------
  // Channel drive
  // ------------------------------------------------------------
  always_comb begin
    drive_d = '0;
    if (in_run)
    begin
      drive_d = ctrl_en & led_s2_q;
    end
    else if (in_safe)
    begin
      drive_d = ctrl_en;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst)
    begin
      drive_q <= '0;
    end
    else
    begin
      drive_q <= drive_d;
    end
  end

  // ------------------------------------------------------------
  // Reply for the next frame
  // ------------------------------------------------------------
  wire [9:0] stat_bits = {4'h0, latch_q, in_safe, safe_flag_q, err_flag_q};

  always_comb begin
    tx_d = tx_q;
    if (frame_bad)
    begin
      tx_d = fsp_pkg::ERR_REPLY;
    end
    else if (frame_ok && is_write)
    begin
      tx_d = rx_word;
    end
    else if (rd_ctrl)
    begin
      tx_d = {rx_word[FW-1:CW], ctrl_q};
    end
    else if (rd_stat)
    begin
      tx_d = {rx_word[FW-1:CW], stat_bits};
    end
    else if (frame_ok)
    begin
      tx_d = {rx_word[FW-1:CW], 10'h000};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst)
    begin
      tx_q <= fsp_pkg::ERR_REPLY;
    end
    else
    begin
      tx_q <= tx_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign ctrl_reg             = ctrl_q;
  assign latched_mode         = latch_q;
  assign init_busy            = in_init;
  assign failsafe_operation   = in_safe & ~solo_now;
  assign standalone_operation = in_safe & solo_now;
  assign failsafe_flag        = safe_flag_q;
  assign serial_error_flag    = err_flag_q;
  assign channel_drive        = drive_q;

endmodule : fsp_failsafe_ctrl

// ### verif/fsp_failsafe_ctrl_asserts.sv
module fsp_failsafe_ctrl_asserts (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // Pins
  input wire logic       external_reset_pin,
  input wire logic       chip_select_n,
  input wire logic       sdo_oe_n,
  input wire logic       otp_lock,
  input wire logic [9:0] otp_image,
  // Status
  input wire logic [9:0] ctrl_reg,
  input wire logic [2:0] latched_mode,
  input wire logic       init_busy,
  input wire logic       failsafe_operation,
  input wire logic       standalone_operation,
  input wire logic       failsafe_flag,
  input wire logic       serial_error_flag,
  input wire logic       daisy_mode,
  input wire logic [1:0] channel_drive
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       in_fs;
  logic [2:0] md;

  assign in_fs = failsafe_operation | standalone_operation;
  assign md    = ctrl_reg[4:2];

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  oe_idle_a: assert property (chip_select_n [*4] |-> sdo_oe_n)
    else $error("data out driven while deselected");
  fso_entry_a: assert property ($fell(external_reset_pin) && otp_lock && !init_busy && !in_fs
    && md inside {[2:5]} |-> ##[2:6] failsafe_operation)
    else $error("pin fall did not enter fail-safe");
  pin_reset_a: assert property ($fell(external_reset_pin) && !init_busy && !in_fs
    && md[2:1] == 2'b00 |-> ##[2:6] init_busy)
    else $error("pin fall did not reset");
  solo_reset_a: assert property ($fell(external_reset_pin) && standalone_operation
    |-> ##[2:6] init_busy)
    else $error("pin fall did not reset stand-alone");
  ctrl_load_a: assert property ($rose(failsafe_operation) |-> ##[0:1] ctrl_reg == otp_image)
    else $error("no reload on fail-safe entry");
  flag_set_a: assert property ($rose(failsafe_operation) |-> ##[0:1] failsafe_flag)
    else $error("fail-safe flag not set on entry");
  mode_latch_a: assert property ($rose(failsafe_operation) |-> ##[0:1] latched_mode inside {[2:5]})
    else $error("mode copy wrong on entry");
  latch_clear_a: assert property (!in_fs [*2] |-> latched_mode == 3'h0)
    else $error("mode copy kept outside fail-safe");
  solo_load_a: assert property ($rose(standalone_operation) |-> ctrl_reg == otp_image
    && latched_mode == otp_image[4:2])
    else $error("stand-alone entry without image or mode copy");
  fs_drive_a: assert property (in_fs [*2] ##0 $stable(ctrl_reg) |-> channel_drive == ctrl_reg[1:0])
    else $error("channel drive not from enable bits");
  err_keep_a: assert property ((serial_error_flag && chip_select_n && external_reset_pin) [*8]
    |=> serial_error_flag)
    else $error("error flag lost without a frame");

  cover property ($rose(failsafe_operation));
  cover property ($rose(standalone_operation));
  cover property ($rose(daisy_mode));
endmodule : fsp_failsafe_ctrl_asserts

bind fsp_failsafe_ctrl fsp_failsafe_ctrl_asserts i_asserts (
  .clk_sys(clk_sys), .rst(rst), .external_reset_pin(external_reset_pin),
  .chip_select_n(chip_select_n), .sdo_oe_n(sdo_oe_n), .otp_lock(otp_lock),
  .otp_image(otp_image), .ctrl_reg(ctrl_reg), .latched_mode(latched_mode),
  .init_busy(init_busy), .failsafe_operation(failsafe_operation),
  .standalone_operation(standalone_operation), .failsafe_flag(failsafe_flag),
  .serial_error_flag(serial_error_flag), .daisy_mode(daisy_mode),
  .channel_drive(channel_drive)
);

// ### verif/fsp_spi_master.sv
module fsp_spi_master (
  // Serial pins
  output logic      chip_select_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo_line
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    chip_select_n = 1'b1;
    sclk          = 1'b0;
    sdi           = 1'b0;
  end

  // Sends w once per frame, drop bits short, and returns the last 16 bits read.
  task automatic xfer(input logic [15:0] w, input int frames, input int drop,
                      output logic [15:0] r);
    int i;
    r = 16'h0000;
    chip_select_n = 1'b0;
    #160;
    for (i = 0; i < frames * 16 - drop; i++)
    begin
      sdi = w[15 - (i % 16)];
      #80 sclk = 1'b1;
      r = {r[14:0], sdo_line};
      #80 sclk = 1'b0;
    end
    #80 chip_select_n = 1'b1;
    sdi = ~sdi;
    #160;
  endtask : xfer
endmodule : fsp_spi_master

// ### verif/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------
  // Signals
  // ----------
  logic        clk_sys;
  logic        rst;
  logic        pin;
  logic [1:0]  led;
  logic        otp_lock;
  logic [9:0]  otp_image;
  logic        cs_n;
  logic        sclk;
  logic        sdi;
  logic        sdo_o;
  logic        sdo_oe_n;
  logic        sdo_line;
  logic [9:0]  ctrl_reg;
  logic [2:0]  latched;
  logic        busy;
  logic        fs_on;
  logic        solo;
  logic        fs_flag;
  logic        err;
  logic        daisy;
  logic [1:0]  drive;
  logic [15:0] rx;
  int          failures = 0;
  int          num_checks = 0;

  // The data line has a pull-up while released.
  assign sdo_line = sdo_oe_n ? 1'b1 : sdo_o;

  fsp_failsafe_ctrl i_fsp_failsafe_ctrl (
    .clk_sys(clk_sys), .rst(rst), .external_reset_pin(pin),
    .led_channel_control_pin(led), .chip_select_n(cs_n), .sclk(sclk),
    .sdi(sdi), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .otp_lock(otp_lock),
    .otp_image(otp_image), .ctrl_reg(ctrl_reg), .latched_mode(latched),
    .init_busy(busy), .failsafe_operation(fs_on), .standalone_operation(solo),
    .failsafe_flag(fs_flag), .serial_error_flag(err), .daisy_mode(daisy),
    .channel_drive(drive)
  );

  fsp_spi_master i_fsp_spi_master (
    .chip_select_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo_line(sdo_line)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ----------
  // Helpers
  // ----------
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, want, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick

  task automatic pin_to(input logic v);
    pin = v;
    tick(8);
  endtask : pin_to

  task automatic wait_init();
    int k;
    for (k = 0; k < 40 && busy !== 1'b0; k++)
      tick(1);
    chk("init done", 16'(busy), 16'h0000);
  endtask : wait_init

  task automatic do_reset(input logic lk, input logic [9:0] img);
    otp_lock  = lk;
    otp_image = img;
    rst       = 1'b1;
    tick(10);
    rst = 1'b0;
    wait_init();
  endtask : do_reset

  task automatic frame(input logic [15:0] w);
    i_fsp_spi_master.xfer(w, 1, 0, rx);
    tick(8);
  endtask : frame

  function automatic logic [9:0] exp_init(input logic lk, input logic [9:0] img);
    logic [2:0] m;
    m = lk ? img[4:2] : 3'h0;
    if (m == 3'h1 || m[2])
      return img;
    return {5'h00, m, 2'h0};
  endfunction : exp_init

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  initial
  begin
    #500000;
    failures++;
    wrap_up();
  end

  // ----------
  // Tests
  // ----------
  initial
  begin
    int         m;
    logic [9:0] img;
    logic [9:0] wd;
    rst       = 1'b1;
    pin       = 1'b1;
    led       = 2'b00;
    otp_lock  = 1'b0;
    otp_image = 10'h000;
    void'($urandom(32'hAB68361A));
    for (m = 0; m < 8; m++)
    begin
      img = 10'($urandom());
      img[4:2] = 3'(m);
      do_reset(1'b1, img);
      chk("init ctrl", 16'(ctrl_reg), 16'(exp_init(1'b1, img)));
      chk("standalone", 16'(solo), 16'(m >= 6));
      if (m >= 2 && m <= 5)
      begin
        pin_to(1'b0);
        chk("safe entry", 16'({fs_on, busy, fs_flag}), 16'h0005);
        chk("safe load", 16'(ctrl_reg), 16'(img));
        chk("safe latch", 16'(latched), 16'(m));
      end
      if (m >= 2)
      begin
        led = ~img[1:0];
        tick(6);
        chk("fs drive", 16'(drive), 16'(img[1:0]));
        wd = {5'($urandom()), 2'b00, 1'($urandom()), led};
        frame({5'h14, 1'b0, wd});
        chk("fs write", 16'(ctrl_reg), 16'(m[0] ? wd : img));
        chk("fs exit", 16'(fs_on | solo), 16'(!m[0]));
        frame(16'h7000);
        chk("fs echo", rx, {5'h14, 1'b0, wd});
        chk("flag read", 16'(fs_flag), 16'(!m[0]));
      end
      if (m >= 2 && m <= 5)
      begin
        pin_to(1'b1);
        chk("safe exit", 16'({fs_on, latched}), 16'h0000);
      end
      else
      begin
        pin_to(1'b0);
        chk("pin reset", 16'({busy, fs_on, ctrl_reg}), 16'h0800);
        pin_to(1'b1);
        wait_init();
      end
      $display("mode %0d test done", m);
    end
    do_reset(1'b0, 10'($urandom()));
    chk("clear ctrl", 16'(ctrl_reg), 16'h0000);
    frame(16'hA003);
    chk("reset reply", rx, 16'h8000);
    chk("write", 16'(ctrl_reg), 16'h0003);
    repeat (6)
    begin
      led = 2'($urandom());
      tick(6);
      chk("led drive", 16'(drive), 16'(led));
    end
    frame(16'h0800);
    chk("echo", rx, 16'hA003);
    i_fsp_spi_master.xfer(16'hFFFF, 1, 1, rx);
    tick(8);
    chk("short frame", 16'(err), 16'h0001);
    frame(16'h7000);
    chk("error reply", rx, 16'h8000);
    chk("err clear", 16'(err), 16'h0000);
    frame(16'h2000);
    chk("status", rx, 16'h7001);
    frame(16'h0800);
    chk("ctrl read", rx, 16'h2003);
    i_fsp_spi_master.xfer(16'h0000, 2, 0, rx);
    tick(8);
    chk("daisy on", 16'(daisy), 16'h0001);
    frame(16'hFFFF);
    chk("daisy off", 16'({daisy, sdo_oe_n}), 16'h0001);
    $display("serial test done");
    wrap_up();
  end
endmodule : tb
